//--- ciu_pkg.sv
package ciu_pkg;

  // ****************************************************************
  // channel map
  // ****************************************************************
  localparam int unsigned NUM_CH          = 32;
  localparam int unsigned IDX_W           = 5;
  localparam int unsigned CH_BROWNOUT     = 0;
  localparam int unsigned CH_EXT_PIN      = 1;
  localparam int unsigned CH_WDOG_EXPIRY  = 2;
  localparam int unsigned CH_WDOG_HALF    = 3;
  localparam int unsigned CH_SER_ERR      = 4;
  localparam int unsigned CH_SER0_RX      = 5;
  localparam int unsigned CH_SER0_TX      = 6;
  localparam int unsigned CH_SER1_RX      = 7;
  localparam int unsigned CH_SER1_TX      = 8;
  localparam int unsigned CH_PMBUS        = 9;
  localparam int unsigned CH_DIG_COMP     = 10;
  localparam int unsigned CH_FRONT_END0   = 11;
  localparam int unsigned CH_SMALL_TMR3   = 14;
  localparam int unsigned CH_WIDE_OVF     = 18;
  localparam int unsigned CH_WIDE_CAP1    = 19;
  localparam int unsigned CH_WIDE_CMP1    = 20;
  localparam int unsigned CH_WIDE_CAP0    = 21;
  localparam int unsigned CH_WIDE_CMP0    = 22;
  localparam int unsigned CH_PWR_LIMIT    = 23;
  localparam int unsigned CH_CONV_DONE    = 24;
  localparam int unsigned CH_FAULT_MUX    = 25;
  localparam int unsigned CH_FINE_MOD3    = 26;
  localparam int unsigned CH_FAULT_PIN    = 30;
  localparam int unsigned CH_SOFTWARE     = 31;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] ADDR_FAST_VEC  = 8'h00;
  localparam logic [7:0] ADDR_NORM_VEC  = 8'h04;
  localparam logic [7:0] ADDR_ROUTE     = 8'h08;
  localparam logic [7:0] ADDR_MASK      = 8'h0c;
  localparam logic [7:0] ADDR_PEND      = 8'h10;
  localparam logic [7:0] ADDR_SOFT_SET  = 8'h14;
  localparam logic [7:0] ADDR_SOFT_CLR  = 8'h18;
  localparam logic [7:0] ADDR_EV_STAT   = 8'h1c;
  localparam logic [7:0] ADDR_EV_CLR    = 8'h20;
  localparam logic [7:0] ADDR_EV_EN     = 8'h24;

  localparam logic [31:0] ROUTE_RST     = 32'h0000_0000;
  localparam logic [31:0] MASK_RST      = 32'h0000_0000;
  localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;
  localparam int unsigned VEC_VALID_BIT = 31;

  // status events of the bus-side interrupt
  localparam int unsigned EV_W          = 2;
  localparam int unsigned EV_FAST_NEW   = 0;
  localparam int unsigned EV_NORM_NEW   = 1;

  typedef struct packed {
    logic       req;
    logic       valid;
    logic [4:0] index;
  } ciu_level_s;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } ciu_apb_req_s;

endpackage

//--- ciu_prio_enc.sv
`timescale 1ns/1ns
// highest-numbered set bit wins
module ciu_prio_enc (
  input  wire logic [31:0] req_i,
  output logic             any_o,
  output logic [4:0]       index_o
);

  always_comb begin
    any_o   = 1'b0;
    index_o = 5'h00;
    for (int i = 0; i < 32; i++) begin
      if (req_i[i]) begin
        any_o   = 1'b1;
        index_o = 5'(i);
      end
    end
  end

endmodule

//--- ciu_central_irq_unit.sv
`timescale 1ns/1ns
// What this block does
// - thirty-two request channels: thirty-one event inputs, channel 31 from software
// - drives a fast request line and a normal request line; fast ranks higher
// - a vector register per line gives the top pending channel index
// - fixed precedence: channel 31 highest, channel 0 lowest
// - each channel has its own mask bit
// - channels 0-3: brownout, external pin, watchdog expiry, watchdog half
// - channel 4 serial error; 5-6 serial0 rx/tx; 7-8 serial1 rx/tx
// - channel 9 pmbus, 10 digital comparator, 24 conversion done
// - channels 11-13 front end combined interrupts
// - channels 14-17 small timers 3 down to 0
// - channels 18-22 wide timer overflow, capture1, compare1, capture0, compare0
// - 23 power limit mode switch, 25 fault mux, 30 fault pin, 31 software
// - channels 26-29 fine modulators 3 down to 0
module ciu_central_irq_unit (
  input  wire logic        CLOCK_I,
  input  wire logic        RESET_I,
  input  wire logic        BROWNOUT_EVENT_I,
  input  wire logic        EXTERNAL_PIN_EVENT_I,
  input  wire logic        WATCHDOG_EXPIRY_EVENT_I,
  input  wire logic        WATCHDOG_HALF_EVENT_I,
  input  wire logic        SERIAL_ERROR_EVENT_I,
  input  wire logic        SERIAL0_RECEIVE_EVENT_I,
  input  wire logic        SERIAL0_TRANSMIT_EVENT_I,
  input  wire logic        SERIAL1_RECEIVE_EVENT_I,
  input  wire logic        SERIAL1_TRANSMIT_EVENT_I,
  input  wire logic        PMBUS_EVENT_I,
  input  wire logic        DIGITAL_COMPARATOR_EVENT_I,
  input  wire logic [2:0]  FRONT_END_EVENT_I,
  input  wire logic [3:0]  SMALL_TIMER_EVENT_I,
  input  wire logic        WIDE_TIMER_OVERFLOW_EVENT_I,
  input  wire logic        WIDE_TIMER_CAPTURE1_EVENT_I,
  input  wire logic        WIDE_TIMER_COMPARE1_EVENT_I,
  input  wire logic        WIDE_TIMER_CAPTURE0_EVENT_I,
  input  wire logic        WIDE_TIMER_COMPARE0_EVENT_I,
  input  wire logic        POWER_CURRENT_LIMIT_EVENT_I,
  input  wire logic        CONVERSION_DONE_EVENT_I,
  input  wire logic        FAULT_MUX_EVENT_I,
  input  wire logic [3:0]  FINE_MODULATOR_EVENT_I,
  input  wire logic        FAULT_PIN_EVENT_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic [31:0]      PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  output logic             FAST_REQUEST_LINE_O,
  output logic             NORMAL_REQUEST_LINE_O,
  output logic             BUS_IRQ_O
);

  // ****************************************************************
  // request gathering
  // ****************************************************************
  logic [31:0]           raw_req;
  logic [31:0]           soft_q;
  logic [31:0]           route_q;
  logic [31:0]           mask_q;
  logic [31:0]           live;
  logic [31:0]           fast_set;
  logic [31:0]           norm_set;
  ciu_pkg::ciu_level_s   fast_c;
  ciu_pkg::ciu_level_s   norm_c;
  ciu_pkg::ciu_level_s   fast_q;
  ciu_pkg::ciu_level_s   norm_q;
  ciu_pkg::ciu_apb_req_s bus;
  logic [ciu_pkg::EV_W-1:0] ev_stat_q;
  logic [ciu_pkg::EV_W-1:0] ev_en_q;
  logic [ciu_pkg::EV_W-1:0] ev_set;

  assign bus = '{psel: PSEL_I, penable: PENABLE_I, pwrite: PWRITE_I,
                 paddr: PADDR_I, pwdata: PWDATA_I};

  always_comb begin
    raw_req = ciu_pkg::ZERO_WORD;
    raw_req[ciu_pkg::CH_BROWNOUT]    = BROWNOUT_EVENT_I;
    raw_req[ciu_pkg::CH_EXT_PIN]     = EXTERNAL_PIN_EVENT_I;
    raw_req[ciu_pkg::CH_WDOG_EXPIRY] = WATCHDOG_EXPIRY_EVENT_I;
    raw_req[ciu_pkg::CH_WDOG_HALF]   = WATCHDOG_HALF_EVENT_I;
    raw_req[ciu_pkg::CH_SER_ERR]     = SERIAL_ERROR_EVENT_I;
    raw_req[ciu_pkg::CH_SER0_RX]     = SERIAL0_RECEIVE_EVENT_I;
    raw_req[ciu_pkg::CH_SER0_TX]     = SERIAL0_TRANSMIT_EVENT_I;
    raw_req[ciu_pkg::CH_SER1_RX]     = SERIAL1_RECEIVE_EVENT_I;
    raw_req[ciu_pkg::CH_SER1_TX]     = SERIAL1_TRANSMIT_EVENT_I;
    raw_req[ciu_pkg::CH_PMBUS]       = PMBUS_EVENT_I;
    raw_req[ciu_pkg::CH_DIG_COMP]    = DIGITAL_COMPARATOR_EVENT_I;
    raw_req[ciu_pkg::CH_CONV_DONE]   = CONVERSION_DONE_EVENT_I;
    for (int i = 0; i < 3; i++) begin
      raw_req[ciu_pkg::CH_FRONT_END0 + i] = FRONT_END_EVENT_I[i];
    end
    // small timer 3 sits on the lowest channel of the group
    for (int i = 0; i < 4; i++) begin
      raw_req[ciu_pkg::CH_SMALL_TMR3 + i] = SMALL_TIMER_EVENT_I[3 - i];
    end
    raw_req[ciu_pkg::CH_WIDE_OVF]    = WIDE_TIMER_OVERFLOW_EVENT_I;
    raw_req[ciu_pkg::CH_WIDE_CAP1]   = WIDE_TIMER_CAPTURE1_EVENT_I;
    raw_req[ciu_pkg::CH_WIDE_CMP1]   = WIDE_TIMER_COMPARE1_EVENT_I;
    raw_req[ciu_pkg::CH_WIDE_CAP0]   = WIDE_TIMER_CAPTURE0_EVENT_I;
    raw_req[ciu_pkg::CH_WIDE_CMP0]   = WIDE_TIMER_COMPARE0_EVENT_I;
    raw_req[ciu_pkg::CH_PWR_LIMIT]   = POWER_CURRENT_LIMIT_EVENT_I;
    raw_req[ciu_pkg::CH_FAULT_MUX]   = FAULT_MUX_EVENT_I;
    raw_req[ciu_pkg::CH_FAULT_PIN]   = FAULT_PIN_EVENT_I;
    raw_req[ciu_pkg::CH_SOFTWARE]    = soft_q[ciu_pkg::CH_SOFTWARE];
    // fine modulator 3 on the lowest channel of the group
    for (int i = 0; i < 4; i++) begin
      raw_req[ciu_pkg::CH_FINE_MOD3 + i] = FINE_MODULATOR_EVENT_I[3 - i];
    end
  end

  // level pending, masked channels dropped; per-channel mask
  assign live = raw_req & mask_q;
  // split by route bit: one selects fast
  assign fast_set = live & route_q;
  assign norm_set = live & ~route_q;

  // ****************************************************************
  // precedence
  // ****************************************************************
  // highest channel wins on each line
  ciu_prio_enc u_fast_enc (
    .req_i   (fast_set),
    .any_o   (fast_c.valid),
    .index_o (fast_c.index)
  );

  ciu_prio_enc u_norm_enc (
    .req_i   (norm_set),
    .any_o   (norm_c.valid),
    .index_o (norm_c.index)
  );

  assign fast_c.req = fast_c.valid;
  assign norm_c.req = norm_c.valid;

  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      fast_q <= '0;
      norm_q <= '0;
    end else begin
      fast_q <= fast_c;
      norm_q <= norm_c;
    end
  end

  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      FAST_REQUEST_LINE_O   <= 1'b0;
      NORMAL_REQUEST_LINE_O <= 1'b0;
    end else begin
      FAST_REQUEST_LINE_O   <= fast_c.req;
      NORMAL_REQUEST_LINE_O <= norm_c.req;
    end
  end

  // ****************************************************************
  // apb slave
  // ****************************************************************
  logic wr_en;
  logic rd_en;
  logic bad_addr;

  // decode used only for the error response, on reads and writes alike
  function automatic logic addr_known(input logic [7:0] a);
    return (a == ciu_pkg::ADDR_FAST_VEC) || (a == ciu_pkg::ADDR_NORM_VEC)
        || (a == ciu_pkg::ADDR_ROUTE)    || (a == ciu_pkg::ADDR_MASK)
        || (a == ciu_pkg::ADDR_PEND)     || (a == ciu_pkg::ADDR_SOFT_SET)
        || (a == ciu_pkg::ADDR_SOFT_CLR) || (a == ciu_pkg::ADDR_EV_STAT)
        || (a == ciu_pkg::ADDR_EV_CLR)   || (a == ciu_pkg::ADDR_EV_EN);
  endfunction

  // zero-wait: access phase completes in its first cycle
  assign wr_en    = bus.psel && bus.penable && bus.pwrite;
  assign rd_en    = bus.psel && bus.penable && !bus.pwrite;
  assign bad_addr = !addr_known(bus.paddr);

  function automatic logic [31:0] vec_word(input ciu_pkg::ciu_level_s l);
    logic [31:0] w;
    w = ciu_pkg::ZERO_WORD;
    w[ciu_pkg::VEC_VALID_BIT] = l.valid;
    w[ciu_pkg::IDX_W-1:0]     = l.index;
    return w;
  endfunction

  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      route_q <= ciu_pkg::ROUTE_RST;
    end else if (wr_en && bus.paddr == ciu_pkg::ADDR_ROUTE) begin
      route_q <= bus.pwdata;
    end
  end

  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      mask_q <= ciu_pkg::MASK_RST;
    end else if (wr_en && bus.paddr == ciu_pkg::ADDR_MASK) begin
      mask_q <= bus.pwdata;
    end
  end

  // software request, only bit 31 is a channel; clear-first is firmware's job
  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      soft_q <= ciu_pkg::ZERO_WORD;
    end else if (wr_en && bus.paddr == ciu_pkg::ADDR_SOFT_SET) begin
      soft_q[ciu_pkg::CH_SOFTWARE] <= soft_q[ciu_pkg::CH_SOFTWARE]
                                      | bus.pwdata[ciu_pkg::CH_SOFTWARE];
    end else if (wr_en && bus.paddr == ciu_pkg::ADDR_SOFT_CLR) begin
      soft_q[ciu_pkg::CH_SOFTWARE] <= soft_q[ciu_pkg::CH_SOFTWARE]
                                      & ~bus.pwdata[ciu_pkg::CH_SOFTWARE];
    end
  end

  // ****************************************************************
  // bus-side interrupt status
  // ****************************************************************
  // new-request edges on each line
  assign ev_set[ciu_pkg::EV_FAST_NEW] = fast_c.req & ~FAST_REQUEST_LINE_O;
  assign ev_set[ciu_pkg::EV_NORM_NEW] = norm_c.req & ~NORMAL_REQUEST_LINE_O;

  // set wins over a same-cycle clear
  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      ev_stat_q <= '0;
    end else if (wr_en && bus.paddr == ciu_pkg::ADDR_EV_CLR) begin
      ev_stat_q <= (ev_stat_q & ~bus.pwdata[ciu_pkg::EV_W-1:0]) | ev_set;
    end else begin
      ev_stat_q <= ev_stat_q | ev_set;
    end
  end

  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      ev_en_q <= '0;
    end else if (wr_en && bus.paddr == ciu_pkg::ADDR_EV_EN) begin
      ev_en_q <= bus.pwdata[ciu_pkg::EV_W-1:0];
    end
  end

  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      BUS_IRQ_O <= 1'b0;
    end else begin
      BUS_IRQ_O <= |(ev_stat_q & ev_en_q);
    end
  end

  // ****************************************************************
  // read path and handshake
  // ****************************************************************
  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      PRDATA_O <= ciu_pkg::ZERO_WORD;
    end else if (bus.psel && !bus.penable && !bus.pwrite) begin
      unique case (bus.paddr)
        // index of top pending channel per line
        ciu_pkg::ADDR_FAST_VEC: PRDATA_O <= vec_word(fast_q);
        ciu_pkg::ADDR_NORM_VEC: PRDATA_O <= vec_word(norm_q);
        ciu_pkg::ADDR_ROUTE:    PRDATA_O <= route_q;
        ciu_pkg::ADDR_MASK:     PRDATA_O <= mask_q;
        ciu_pkg::ADDR_PEND:     PRDATA_O <= raw_req;
        ciu_pkg::ADDR_SOFT_SET: PRDATA_O <= soft_q;
        ciu_pkg::ADDR_EV_STAT:  PRDATA_O <= {30'h0, ev_stat_q};
        ciu_pkg::ADDR_EV_EN:    PRDATA_O <= {30'h0, ev_en_q};
        default:                PRDATA_O <= ciu_pkg::ZERO_WORD;
      endcase
    end
  end

  // ready rises with penable; answer ends with penable
  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
    end else begin
      PREADY_O  <= bus.psel && !bus.penable;
      PSLVERR_O <= bus.psel && !bus.penable && bad_addr;
    end
  end

  logic unused_rd;
  assign unused_rd = rd_en;

endmodule

//--- ciu_assertions.sv
`timescale 1ns/1ns
module ciu_assertions (
  input wire logic        CLOCK_I,
  input wire logic        RESET_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [7:0]  PADDR_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  input wire logic        FAST_REQUEST_LINE_O,
  input wire logic        NORMAL_REQUEST_LINE_O,
  input wire logic        BUS_IRQ_O
);
  // ****************************************************************
  // bus and line checks
  // ****************************************************************
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RESET_I);

  sequence s_setup;
    PSEL_I && !PENABLE_I;
  endsequence
  sequence s_access;
    PSEL_I && PENABLE_I && PREADY_O;
  endsequence

  property p_zero_wait;
    s_setup |=> s_access;
  endproperty
  property p_ready_cause;
    PREADY_O |-> $past(PSEL_I && !PENABLE_I);
  endproperty
  property p_ready_pulse;
    PREADY_O |=> !PREADY_O;
  endproperty
  property p_err_with_ready;
    PSLVERR_O |-> PREADY_O;
  endproperty
  // unmapped reads return zero
  property p_unmapped;
    PREADY_O && PADDR_I > 8'h24 |-> PSLVERR_O && (PWRITE_I || PRDATA_O == 32'h0);
  endproperty
  property p_mapped_ok;
    PREADY_O && PADDR_I <= 8'h24 && PADDR_I[1:0] == 2'b00 |-> !PSLVERR_O;
  endproperty
  property p_idle_quiet;
    !PSEL_I |-> !PREADY_O && !PSLVERR_O;
  endproperty
  // both request lines and the bus interrupt are low as reset falls
  property p_reset_quiet;
    $fell(RESET_I) |-> !FAST_REQUEST_LINE_O && !NORMAL_REQUEST_LINE_O && !BUS_IRQ_O;
  endproperty

  a_zero_wait: assert property (p_zero_wait)
    else $error("no ready after setup");
  a_ready_cause: assert property (p_ready_cause)
    else $error("ready without setup");
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready longer than one cycle");
  a_err_with_ready: assert property (p_err_with_ready)
    else $error("error without ready");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (p_mapped_ok)
    else $error("mapped access refused");
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("answer while idle");
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("output high after reset");
endmodule

bind ciu_central_irq_unit ciu_assertions u_chk (
  .CLOCK_I(CLOCK_I), .RESET_I(RESET_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
  .PSLVERR_O(PSLVERR_O), .FAST_REQUEST_LINE_O(FAST_REQUEST_LINE_O),
  .NORMAL_REQUEST_LINE_O(NORMAL_REQUEST_LINE_O), .BUS_IRQ_O(BUS_IRQ_O)
);

//--- ciu_core_model.sv
`timescale 1ns/1ns
module ciu_core_model (
  input  wire logic   clk_i,
  input  wire logic   rst_i,
  input  wire logic   fast_i,
  input  wire logic   norm_i,
  output int unsigned fast_takes_o,
  output int unsigned norm_takes_o
);
  // ****************************************************************
  // core side: counts requests taken on each level
  // ****************************************************************
  logic fast_q;
  logic norm_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fast_q       <= 1'b0;
      norm_q       <= 1'b0;
      fast_takes_o <= 0;
      norm_takes_o <= 0;
    end else begin
      fast_q <= fast_i;
      norm_q <= norm_i;
      if (fast_i && !fast_q) begin
        fast_takes_o <= fast_takes_o + 1;
      end
      if (norm_i && !norm_q) begin
        norm_takes_o <= norm_takes_o + 1;
      end
    end
  end
endmodule

//--- tb_central_interrupt_module.sv
`timescale 1ns/1ns
module tb_central_interrupt_module;
  // ****************************************************************
  // bench
  // ****************************************************************
  logic                  clk, rst, fast, norm, bus_irq, pready, pslverr, e;
  logic [31:0]           ev, prdata, q, r, msk, rt;
  ciu_pkg::ciu_apb_req_s req;
  int                    n_errors = 0;
  int                    checks = 0;
  int unsigned           fast_n, norm_n, f0;

  ciu_central_irq_unit DUT (
    .CLOCK_I(clk), .RESET_I(rst), .BROWNOUT_EVENT_I(ev[0]), .EXTERNAL_PIN_EVENT_I(ev[1]),
    .WATCHDOG_EXPIRY_EVENT_I(ev[2]), .WATCHDOG_HALF_EVENT_I(ev[3]),
    .SERIAL_ERROR_EVENT_I(ev[4]), .SERIAL0_RECEIVE_EVENT_I(ev[5]),
    .SERIAL0_TRANSMIT_EVENT_I(ev[6]), .SERIAL1_RECEIVE_EVENT_I(ev[7]),
    .SERIAL1_TRANSMIT_EVENT_I(ev[8]), .PMBUS_EVENT_I(ev[9]),
    .DIGITAL_COMPARATOR_EVENT_I(ev[10]), .FRONT_END_EVENT_I(ev[13:11]),
    .SMALL_TIMER_EVENT_I({ev[14], ev[15], ev[16], ev[17]}),
    .WIDE_TIMER_OVERFLOW_EVENT_I(ev[18]), .WIDE_TIMER_CAPTURE1_EVENT_I(ev[19]),
    .WIDE_TIMER_COMPARE1_EVENT_I(ev[20]), .WIDE_TIMER_CAPTURE0_EVENT_I(ev[21]),
    .WIDE_TIMER_COMPARE0_EVENT_I(ev[22]), .POWER_CURRENT_LIMIT_EVENT_I(ev[23]),
    .CONVERSION_DONE_EVENT_I(ev[24]), .FAULT_MUX_EVENT_I(ev[25]),
    .FINE_MODULATOR_EVENT_I({ev[26], ev[27], ev[28], ev[29]}), .FAULT_PIN_EVENT_I(ev[30]),
    .PSEL_I(req.psel), .PENABLE_I(req.penable), .PWRITE_I(req.pwrite),
    .PADDR_I(req.paddr), .PWDATA_I(req.pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .FAST_REQUEST_LINE_O(fast), .NORMAL_REQUEST_LINE_O(norm),
    .BUS_IRQ_O(bus_irq)
  );

  ciu_core_model u_core (
    .clk_i(clk), .rst_i(rst), .fast_i(fast), .norm_i(norm),
    .fast_takes_o(fast_n), .norm_takes_o(norm_n)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], 1'b0} ^ (s[31] ? 32'h04c1_1db7 : 32'h0);
  endfunction

  // top enabled channel routed to one line, valid in bit 31
  function automatic logic [31:0] vec(input logic [31:0] p, m, t, input logic f);
    logic [31:0] c;
    c = p & m & (f ? t : ~t);
    vec = 32'h0;
    for (int i = 0; i < 32; i++) begin
      if (c[i]) vec = 32'h8000_0000 | 32'(i);
    end
  endfunction

  task automatic chk(input logic [31:0] got, exp, input string m);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // hold the request until ready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rq, output logic er);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    // ready, read data and error are taken only at a rising edge
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (pready !== 1'b1) begin
      n_errors++;
      $display("MISMATCH t=%0t no ready", $time);
    end
    rq = prdata;
    er = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic summarize();
    $display("checks=%0d errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    n_errors++;
    summarize();
  end

  initial begin
    rst = 1'b1;
    req = '0;
    ev = '0;
    r = 32'hc08cb6a6;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, ciu_pkg::ADDR_MASK, 32'h0, q, e);
    chk(q, ciu_pkg::MASK_RST, "mask reset");
    apb(1'b0, ciu_pkg::ADDR_ROUTE, 32'h0, q, e);
    chk(q, ciu_pkg::ROUTE_RST, "route reset");
    // random sources, masks and routes; first two are corners
    for (int k = 0; k < 14; k++) begin
      r = lfsr(r);
      msk = (k == 0) ? 32'hffff_ffff : (k == 1) ? 32'h0 : r;
      r = lfsr(r);
      rt = (k == 0) ? 32'h0000_ffff : r;
      r = lfsr(r);
      apb(1'b1, ciu_pkg::ADDR_MASK, msk, q, e);
      apb(1'b1, ciu_pkg::ADDR_ROUTE, rt, q, e);
      ev <= (k < 2) ? 32'h7fff_ffff : {1'b0, r[30:0]};
      repeat (3) @(posedge clk);
      apb(1'b0, ciu_pkg::ADDR_FAST_VEC, 32'h0, q, e);
      chk(q, vec(ev, msk, rt, 1'b1), "fast vector");
      apb(1'b0, ciu_pkg::ADDR_NORM_VEC, 32'h0, q, e);
      chk(q, vec(ev, msk, rt, 1'b0), "normal vector");
      chk({31'h0, fast}, {31'h0, |(ev & msk & rt)}, "fast line");
      chk({31'h0, norm}, {31'h0, |(ev & msk & ~rt)}, "normal line");
      apb(1'b0, ciu_pkg::ADDR_PEND, 32'h0, q, e);
      chk(q, ev, "raw pending");
    end
    apb(1'b1, ciu_pkg::ADDR_MASK, 32'hffff_ffff, q, e);
    apb(1'b1, ciu_pkg::ADDR_ROUTE, 32'h0, q, e);
    // one source at a time lands on its own channel
    for (int ch = 0; ch < 31; ch++) begin
      ev <= 32'h1 << ch;
      repeat (3) @(posedge clk);
      apb(1'b0, ciu_pkg::ADDR_NORM_VEC, 32'h0, q, e);
      chk(q, 32'h8000_0000 | 32'(ch), "channel map");
    end
    ev <= 32'h4000_0000;
    apb(1'b1, ciu_pkg::ADDR_ROUTE, 32'h8000_0000, q, e);
    apb(1'b1, ciu_pkg::ADDR_SOFT_SET, 32'h8000_0000, q, e);
    apb(1'b0, ciu_pkg::ADDR_FAST_VEC, 32'h0, q, e);
    chk(q, 32'h8000_001f, "software channel");
    apb(1'b0, ciu_pkg::ADDR_NORM_VEC, 32'h0, q, e);
    chk(q, 32'h8000_001e, "fault pin channel");
    apb(1'b1, ciu_pkg::ADDR_SOFT_CLR, 32'h8000_0000, q, e);
    apb(1'b0, ciu_pkg::ADDR_FAST_VEC, 32'h0, q, e);
    chk(q, 32'h0, "software cleared");
    // status, enable and clear of the bus interrupt
    ev <= 32'h0;
    apb(1'b1, ciu_pkg::ADDR_ROUTE, 32'hffff_ffff, q, e);
    apb(1'b1, ciu_pkg::ADDR_EV_EN, 32'h1, q, e);
    apb(1'b1, ciu_pkg::ADDR_EV_CLR, 32'h3, q, e);
    repeat (2) @(posedge clk);
    chk({31'h0, bus_irq}, 32'h0, "irq cleared");
    f0 = fast_n;
    ev <= 32'h20;
    repeat (4) @(posedge clk);
    chk({31'h0, bus_irq}, 32'h1, "irq raised");
    chk(fast_n - f0, 32'h1, "core took fast");
    ev <= 32'h0;
    apb(1'b1, ciu_pkg::ADDR_EV_EN, 32'h0, q, e);
    repeat (2) @(posedge clk);
    chk({31'h0, bus_irq}, 32'h0, "irq masked");
    apb(1'b0, ciu_pkg::ADDR_EV_STAT, 32'h0, q, e);
    chk(q & 32'h1, 32'h1, "status sticky");
    apb(1'b1, ciu_pkg::ADDR_EV_CLR, 32'h1, q, e);
    apb(1'b0, ciu_pkg::ADDR_EV_STAT, 32'h0, q, e);
    chk(q & 32'h1, 32'h0, "status cleared");
    // unmapped place is refused and writes there change nothing
    apb(1'b1, 8'h80, 32'h0, q, e);
    apb(1'b0, 8'h40, 32'h0, q, e);
    chk({q[30:0], e}, 32'h1, "unmapped refused");
    apb(1'b0, ciu_pkg::ADDR_MASK, 32'h0, q, e);
    chk(q, 32'hffff_ffff, "mask kept");
    summarize();
  end
endmodule
